// ==== src/cpu_alu_cfg.svh ====
`ifndef CPU_ALU_CFG_SVH
`define CPU_ALU_CFG_SVH

// register port map, word indexes
`define ADDR_W 4
`define CORE_CONTROL_ADDR 4'h0
`define STATUS_WORD_ADDR 4'h1

// core_control fields and reset
`define CC_MSB_BIT 3
`define CC_WINDOW_BIT 2
`define CC_RESET 16'h0000

// status_word fields and reset
`define SW_DC_BIT 8
`define SW_IPL_HI 7
`define SW_IPL_LO 5
`define SW_RA_BIT 4
`define SW_N_BIT 3
`define SW_OV_BIT 2
`define SW_Z_BIT 1
`define SW_C_BIT 0
`define SW_RESET 16'h0000

// datapath sizes
`define BYTE_MSB 7
`define NIB_W 4
`define BYTE_W 8
`define WORD_W 16
`define SHIFT_LIMIT 6'h10

// divider: iteration steps, one per divisor bit, and the whole sequence length
`define DIV_STEPS 5'h10
`define DIV_TOTAL_CYCLES 19

`endif

// ==== src/cpu_alu_pkg.sv ====
package cpu_alu_pkg;

	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_ADD = 4'b0001,
		OP_ADDC = 4'b0010,
		OP_SUB = 4'b0011,
		OP_SUBB = 4'b0100,
		OP_AND = 4'b0101,
		OP_OR = 4'b0110,
		OP_XOR = 4'b0111,
		OP_SHIFT = 4'b1000,
		OP_MUL = 4'b1001,
		OP_DIV = 4'b1010
	} aluop_type;

	typedef enum logic [2:0] {
		MUL_SS = 3'b000,
		MUL_UU = 3'b001,
		MUL_US = 3'b010,
		MUL_SU = 3'b011,
		MUL_SLIT = 3'b100,
		MUL_ULIT = 3'b101,
		MUL_BYTE = 3'b110
	} mulmode_type;

	typedef enum logic [1:0] {
		DIV_S32 = 2'b00,
		DIV_U32 = 2'b01,
		DIV_S16 = 2'b10,
		DIV_U16 = 2'b11
	} divmode_type;

	typedef enum logic [1:0] {
		DIV_IDLE = 2'b00,
		DIV_LOAD = 2'b01,
		DIV_ITER = 2'b10,
		DIV_FIX = 2'b11
	} divstate_type;

	typedef struct packed {
		aluop_type op;
		logic byteMode;
		logic srcMem;
		logic destMem;
		logic shiftArith;
		mulmode_type mulMode;
		divmode_type divMode;
		logic [4:0] literal;
		logic signed [5:0] shiftAmount;
	} request_type;

	typedef struct packed {
		logic dc;
		logic n;
		logic ov;
		logic z;
		logic c;
	} flags_type;

endpackage

// ==== src/cpu_alu_mul_div_shift.sv ====
// Operation
// - core_control bits 15-4, 1-0 read zero
// - priority msb: reset zero, read/clear, hardware set
// - priority level is msb over status bits 7-5
// - bit 2 read/write program window enable
// - 16-bit two's complement add, sub, shift, logic
// - operations update carry, zero, negative, overflow, digit; here add/sub set all five, logic/shift only zero, negative
// - subtraction: carry is inverted borrow, digit carry inverted digit borrow
// - byte or word operand width per instruction
// - operands from registers or memory, either destination
// - 17x17 multiplier, four 16x16 sign forms
// - 16-bit times unsigned 5-bit literal
// - 8-bit unsigned times 8-bit unsigned
// - divide 32/16 and 16/16, signed and unsigned
// - quotient to register zero, remainder to one
// - divisor any register, dividend aligned odd:even pair
// - one step per divisor bit, same length
// - shift right or left up to 16, one cycle
// - shift source register or memory
// - signed amount: positive right, negative left, zero none
// - divide takes 19 cycles, interruptible without loss
// - digit carry from bit 4 byte, 8 word
// - priority msb set disables user interrupts
// - overflow on signed magnitude overflow changing sign
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "cpu_alu_cfg.svh"

module cpu_alu_mul_div_shift
	import cpu_alu_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [`ADDR_W-1:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdata,
	input wire logic reqValid,
	input wire request_type req,
	input wire logic [15:0] wregA,
	input wire logic [15:0] wregB,
	input wire logic [15:0] memData,
	input wire logic [15:0] dividendHigh,
	input wire logic [15:0] dividendLow,
	input wire logic [15:0] divisor,
	input wire logic divHold,
	input wire logic priorityMsbSet,
	input wire logic repeatActive,
	output logic [15:0] result,
	output logic [15:0] resultHigh,
	output logic resultValid,
	output logic resultToMem,
	output logic resultByte,
	output logic resultWide,
	output logic [15:0] quotient,
	output logic [15:0] remainder,
	output logic divWrite,
	output logic divBusy,
	output logic [15:0] statusWord,
	output logic [3:0] priorityLevel,
	output logic userIrqDisable,
	output logic programWindowEnable
);

	logic priorityMsb;
	logic [2:0] priorityLow;
	flags_type flags;
	logic repeatSeen;
	flags_type next_flags;
	logic flagsLoad;
	logic flagsArith;
	logic [15:0] next_result;
	logic [15:0] next_resultHigh;
	logic [15:0] opA;
	logic [15:0] opB;
	logic carryIn;
	logic [16:0] sumWord;
	logic [8:0] sumByte;
	logic [4:0] sumNib;
	logic resMsb;
	logic aMsb;
	logic bMsb;
	logic [5:0] shiftMag;
	logic [15:0] shiftOut;
	logic [16:0] mulA;
	logic [16:0] mulB;
	logic signed [33:0] product;
	logic ccWrite;
	logic swWrite;
	divstate_type divState;
	divmode_type divMode;
	logic [4:0] divCount;
	logic [31:0] rawDividend;
	logic [15:0] rawDivisor;
	logic [15:0] absDivisor;
	logic [15:0] remReg;
	logic [15:0] quoReg;
	logic negQuo;
	logic negRem;
	logic [16:0] trial;
	logic [31:0] loadDividend;
	logic divSigned;
	// reset words held as constants so single fields can be selected
	localparam logic [15:0] ccReset = `CC_RESET;
	localparam logic [15:0] swReset = `SW_RESET;

	assign ccWrite = regWrite && (regAddr == `CORE_CONTROL_ADDR);
	assign swWrite = regWrite && (regAddr == `STATUS_WORD_ADDR);

	// priority msb: software may only clear; a hardware set in the same cycle wins
	always_ff @(posedge clk) begin
		if (!nrst) begin
			priorityMsb <= ccReset[`CC_MSB_BIT];
		end else if (priorityMsbSet) begin
			priorityMsb <= 1'b1;
		end else if (ccWrite && !regWdata[`CC_MSB_BIT]) begin
			priorityMsb <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			programWindowEnable <= ccReset[`CC_WINDOW_BIT];
		end else if (ccWrite) begin
			programWindowEnable <= regWdata[`CC_WINDOW_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			userIrqDisable <= 1'b0;
		end else begin
			userIrqDisable <= priorityMsbSet || (priorityMsb && !(ccWrite && !regWdata[`CC_MSB_BIT]));
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			priorityLow <= swReset[`SW_IPL_HI:`SW_IPL_LO];
		end else if (swWrite) begin
			priorityLow <= regWdata[`SW_IPL_HI:`SW_IPL_LO];
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			repeatSeen <= swReset[`SW_RA_BIT];
		end else begin
			repeatSeen <= repeatActive;
		end
	end

	// flag updates from the datapath take priority over a software write
	always_ff @(posedge clk) begin
		if (!nrst) begin
			flags <= '0;
		end else if (flagsLoad) begin
			flags <= next_flags;
		end else if (swWrite) begin
			flags.dc <= regWdata[`SW_DC_BIT];
			flags.n <= regWdata[`SW_N_BIT];
			flags.ov <= regWdata[`SW_OV_BIT];
			flags.z <= regWdata[`SW_Z_BIT];
			flags.c <= regWdata[`SW_C_BIT];
		end
	end

	always_comb begin
		statusWord = '0;
		statusWord[`SW_DC_BIT] = flags.dc;
		statusWord[`SW_IPL_HI:`SW_IPL_LO] = priorityLow;
		statusWord[`SW_RA_BIT] = repeatSeen;
		statusWord[`SW_N_BIT] = flags.n;
		statusWord[`SW_OV_BIT] = flags.ov;
		statusWord[`SW_Z_BIT] = flags.z;
		statusWord[`SW_C_BIT] = flags.c;
	end

	assign priorityLevel = {priorityMsb, priorityLow};

	always_ff @(posedge clk) begin
		if (!nrst) begin
			regRdata <= '0;
		end else if (regRead && regAddr == `CORE_CONTROL_ADDR) begin
			regRdata <= '0;
			regRdata[`CC_MSB_BIT] <= priorityMsb;
			regRdata[`CC_WINDOW_BIT] <= programWindowEnable;
		end else if (regRead && regAddr == `STATUS_WORD_ADDR) begin
			regRdata <= statusWord;
		end else begin
			regRdata <= '0;
		end
	end

	assign opA = req.srcMem ? memData : wregA;

	// subtraction runs as a + ~b + 1, so carry out high means no borrow
	always_comb begin
		opB = wregB;
		carryIn = 1'b0;
		case (req.op)
			OP_SUB: begin
				opB = ~wregB;
				carryIn = 1'b1;
			end
			OP_SUBB: begin
				opB = ~wregB;
				carryIn = flags.c;
			end
			OP_ADDC: begin
				carryIn = flags.c;
			end
			default: begin
				carryIn = 1'b0;
			end
		endcase
	end

	assign sumWord = {1'b0, opA} + {1'b0, opB} + {16'h0000, carryIn};
	assign sumByte = {1'b0, opA[7:0]} + {1'b0, opB[7:0]} + {8'h00, carryIn};
	assign sumNib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};

	assign shiftMag = req.shiftAmount[5] ? 6'(~req.shiftAmount + 6'sh01) : req.shiftAmount;

	// left magnitudes of sixteen or more give zero; right shifts that far leave only zeros or sign bits
	always_comb begin
		if (req.shiftAmount == 6'sh00) begin
			shiftOut = opA;
		end else if (req.shiftAmount[5]) begin
			shiftOut = (shiftMag >= `SHIFT_LIMIT) ? 16'h0000 : 16'(opA << shiftMag);
		end else if (req.shiftArith) begin
			shiftOut = 16'($signed(opA) >>> shiftMag);
		end else begin
			shiftOut = 16'(opA >> shiftMag);
		end
	end

	// one signed 17x17 product covers every sign mix
	always_comb begin
		mulA = {opA[15], opA};
		mulB = {wregB[15], wregB};
		case (req.mulMode)
			MUL_SS: begin
				mulA = {opA[15], opA};
				mulB = {wregB[15], wregB};
			end
			MUL_UU: begin
				mulA = {1'b0, opA};
				mulB = {1'b0, wregB};
			end
			MUL_US: begin
				mulA = {1'b0, opA};
				mulB = {wregB[15], wregB};
			end
			MUL_SU: begin
				mulA = {opA[15], opA};
				mulB = {1'b0, wregB};
			end
			MUL_SLIT: begin
				mulA = {opA[15], opA};
				mulB = {12'h000, req.literal};
			end
			MUL_ULIT: begin
				mulA = {1'b0, opA};
				mulB = {12'h000, req.literal};
			end
			MUL_BYTE: begin
				mulA = {9'h000, opA[7:0]};
				mulB = {9'h000, wregB[7:0]};
			end
			default: begin
				mulA = {opA[15], opA};
				mulB = {wregB[15], wregB};
			end
		endcase
	end

	assign product = $signed(mulA) * $signed(mulB);

	always_comb begin
		next_result = 16'h0000;
		next_resultHigh = 16'h0000;
		flagsArith = 1'b0;
		flagsLoad = 1'b0;
		case (req.op)
			OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
				next_result = sumWord[15:0];
				flagsArith = 1'b1;
				flagsLoad = reqValid;
			end
			OP_AND: begin
				next_result = opA & wregB;
				flagsLoad = reqValid;
			end
			OP_OR: begin
				next_result = opA | wregB;
				flagsLoad = reqValid;
			end
			OP_XOR: begin
				next_result = opA ^ wregB;
				flagsLoad = reqValid;
			end
			OP_SHIFT: begin
				next_result = shiftOut;
				flagsLoad = reqValid;
			end
			OP_MUL: begin
				next_result = product[15:0];
				next_resultHigh = product[31:16];
			end
			default: begin
				next_result = 16'h0000;
			end
		endcase
		if (req.byteMode && req.op != OP_MUL) begin
			next_result = {8'h00, next_result[7:0]};
		end
	end

	assign resMsb = req.byteMode ? next_result[`BYTE_MSB] : next_result[15];
	assign aMsb = req.byteMode ? opA[`BYTE_MSB] : opA[15];
	assign bMsb = req.byteMode ? opB[`BYTE_MSB] : opB[15];

	always_comb begin
		next_flags = flags;
		next_flags.n = resMsb;
		next_flags.z = req.byteMode ? (next_result[7:0] == 8'h00) : (next_result == 16'h0000);
		if (flagsArith) begin
			next_flags.c = req.byteMode ? sumByte[`BYTE_W] : sumWord[`WORD_W];
			next_flags.dc = req.byteMode ? sumNib[`NIB_W] : sumByte[`BYTE_W];
			next_flags.ov = (aMsb == bMsb) && (resMsb != aMsb);
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			result <= '0;
			resultHigh <= '0;
			resultValid <= 1'b0;
			resultToMem <= 1'b0;
			resultByte <= 1'b0;
			resultWide <= 1'b0;
		end else begin
			result <= next_result;
			resultHigh <= next_resultHigh;
			resultValid <= reqValid && req.op != OP_NONE && req.op != OP_DIV;
			resultToMem <= req.destMem;
			resultByte <= req.byteMode && req.op != OP_MUL;
			resultWide <= req.op == OP_MUL;
		end
	end

	// divider: sign handling around a restoring unsigned core
	assign divSigned = (divMode == DIV_S32) || (divMode == DIV_S16);
	assign trial = {remReg, quoReg[15]};
	assign loadDividend = (divSigned && rawDividend[31]) ? 32'(~rawDividend + 32'h1) : rawDividend;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			divState <= DIV_IDLE;
			divMode <= DIV_S32;
			divCount <= '0;
			rawDividend <= '0;
			rawDivisor <= '0;
			absDivisor <= '0;
			remReg <= '0;
			quoReg <= '0;
			negQuo <= 1'b0;
			negRem <= 1'b0;
		end else begin
			case (divState)
				DIV_IDLE: begin
					if (reqValid && req.op == OP_DIV) begin
						divMode <= req.divMode;
						rawDivisor <= divisor;
						case (req.divMode)
							DIV_S32, DIV_U32: rawDividend <= {dividendHigh, dividendLow};
							DIV_S16: rawDividend <= {{16{dividendLow[15]}}, dividendLow};
							default: rawDividend <= {16'h0000, dividendLow};
						endcase
						divState <= DIV_LOAD;
					end
				end
				// a hold from interrupt entry freezes the LOAD, ITER and FIX states so nothing is lost
				DIV_LOAD: begin
					if (!divHold) begin
						remReg <= loadDividend[31:16];
						quoReg <= loadDividend[15:0];
						absDivisor <= (divSigned && rawDivisor[15]) ? 16'(~rawDivisor + 16'h1) : rawDivisor;
						negQuo <= divSigned && (rawDividend[31] ^ rawDivisor[15]);
						negRem <= divSigned && rawDividend[31];
						divCount <= '0;
						divState <= DIV_ITER;
					end
				end
				DIV_ITER: begin
					if (!divHold) begin
						if (trial >= {1'b0, absDivisor}) begin
							remReg <= 16'(trial - {1'b0, absDivisor});
							quoReg <= {quoReg[14:0], 1'b1};
						end else begin
							remReg <= trial[15:0];
							quoReg <= {quoReg[14:0], 1'b0};
						end
						divCount <= 5'(divCount + 5'h01);
						if (divCount == 5'(`DIV_STEPS - 5'h01)) begin
							divState <= DIV_FIX;
						end
					end
				end
				DIV_FIX: begin
					if (!divHold) begin
						divState <= DIV_IDLE;
					end
				end
				default: begin
					divState <= DIV_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			quotient <= '0;
			remainder <= '0;
			divWrite <= 1'b0;
		end else begin
			divWrite <= 1'b0;
			if (divState == DIV_FIX && !divHold) begin
				quotient <= negQuo ? 16'(~quoReg + 16'h1) : quoReg;
				remainder <= negRem ? 16'(~remReg + 16'h1) : remReg;
				divWrite <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			divBusy <= 1'b0;
		end else begin
			divBusy <= (divState == DIV_IDLE) ? (reqValid && req.op == OP_DIV) : !(divState == DIV_FIX && !divHold);
		end
	end

endmodule // cpu_alu_mul_div_shift

// ==== tb/operand_bank.sv ====
`timescale 1ns/1ps

module operand_bank (
	input wire logic clk,
	input wire logic [3:0] selA,
	input wire logic [3:0] selB,
	input wire logic [3:0] selDiv,
	input wire logic [3:0] selPair,
	input wire logic divWrite,
	input wire logic [15:0] quotient,
	input wire logic [15:0] remainder,
	output logic [15:0] wregA,
	output logic [15:0] wregB,
	output logic [15:0] memData,
	output logic [15:0] divisor,
	output logic [15:0] dividendHigh,
	output logic [15:0] dividendLow
);
	logic [15:0] w [16];
	logic [15:0] mem;
	assign wregA = w[selA];
	assign wregB = w[selB];
	assign memData = mem;
	assign divisor = w[selDiv];
	// pair forced even so an odd index cannot split a dividend
	assign dividendLow = w[{selPair[3:1], 1'b0}];
	assign dividendHigh = w[{selPair[3:1], 1'b1}];
	always @(posedge clk) begin
		if (divWrite) begin
			w[0] <= quotient;
			w[1] <= remainder;
		end
	end
endmodule // operand_bank

// ==== tb/cpu_alu_mul_div_shift_checker.sv ====
`timescale 1ns/1ps

module alu_rule_checker
	import cpu_alu_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regRdata,
	input wire logic reqValid,
	input wire request_type req,
	input wire logic [15:0] wregA,
	input wire logic divHold,
	input wire logic priorityMsbSet,
	input wire logic [15:0] result,
	input wire logic resultValid,
	input wire logic divWrite,
	input wire logic divBusy,
	input wire logic [15:0] statusWord,
	input wire logic [3:0] priorityLevel,
	input wire logic userIrqDisable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// held cycles do not count, so the figure stays fixed under interrupts
	logic [5:0] divCount;
	always_ff @(posedge clk) begin
		if (!nrst) divCount <= 6'h00;
		else if (reqValid && req.op == OP_DIV && !divBusy) divCount <= 6'h01;
		else if (divBusy && !divHold) divCount <= divCount + 6'h01;
	end
	read_zero_a: assert property (
		regRead && regAddr == 4'h0 |=> regRdata[15:4] == 12'h000 && regRdata[1:0] == 2'h0)
		else $error("core control spare bits not zero");
	msb_set_a: assert property (
		priorityMsbSet |=> priorityLevel[3] && userIrqDisable)
		else $error("priority msb not set");
	msb_keep_a: assert property (
		regWrite && regAddr == 4'h0 && !priorityLevel[3] && !priorityMsbSet |=> !priorityLevel[3])
		else $error("priority msb set by software");
	level_join_a: assert property (
		priorityLevel == {userIrqDisable, statusWord[7:5]})
		else $error("priority level not joined");
	result_valid_a: assert property (
		resultValid == $past(reqValid && req.op != OP_NONE && req.op != OP_DIV))
		else $error("result valid mistimed");
	div_len_a: assert property (
		divWrite |-> divCount == 6'h13)
		else $error("divide length wrong");
	div_end_a: assert property (
		divWrite |-> !divBusy ##1 !divWrite)
		else $error("divide end wrong");
	shift_zero_a: assert property (
		reqValid && req.op == OP_SHIFT && req.shiftAmount == 6'h00 && !req.srcMem
		&& !req.byteMode |=> result == $past(wregA))
		else $error("zero shift changed operand");
	zero_flag_a: assert property (
		reqValid && req.op == OP_AND && !req.srcMem && wregA == 16'h0000
		|=> statusWord[1] && !statusWord[3])
		else $error("zero flag wrong");
	cover property (divWrite && divCount == 6'h13);
	cover property (resultValid && statusWord[2]);
	cover property (priorityLevel[3]);
endmodule // alu_rule_checker

bind cpu_alu_mul_div_shift alu_rule_checker chk (.clk, .nrst, .regAddr, .regWdata, .regWrite,
	.regRead, .regRdata, .reqValid, .req, .wregA, .divHold, .priorityMsbSet, .result,
	.resultValid, .divWrite, .divBusy, .statusWord, .priorityLevel, .userIrqDisable);

// ==== tb/cpu_alu_mul_div_shift_bench.sv ====
`timescale 1ns/1ps

module cpu_alu_mul_div_shift_bench;
	import cpu_alu_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, regWrite = 1'b0, regRead = 1'b0, reqValid = 1'b0;
	logic divHold = 1'b0, priorityMsbSet = 1'b0, repeatActive = 1'b0;
	logic [3:0] regAddr = 4'h0, selA = 4'h0, selB = 4'h1, selDiv = 4'h7, selPair = 4'h4;
	logic [15:0] regWdata = 16'h0000, regRdata, result, resultHigh, quotient, remainder;
	logic [15:0] wregA, wregB, memData, dividendHigh, dividendLow, divisor, statusWord;
	logic resultValid, resultToMem, resultByte, resultWide, divWrite, divBusy;
	logic userIrqDisable, programWindowEnable;
	logic [3:0] priorityLevel, k;
	logic [7:0] g;
	logic [15:0] x, y, z, e, f;
	request_type req = '0, r;
	int err_count = 0, cmp_count = 0, n;
	aluop_type ao [11] = '{OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_SUB, OP_SUB, OP_AND, OP_OR,
		OP_XOR, OP_ADDC, OP_SUBB};
	// mode(byte,mem) a b result flags{dc,n,ov,z,c}
	logic [59:0] at [11] = '{60'h0_7fff_0001_8000_1c, 60'h0_ffff_0001_0000_13,
		60'h2_120f_0001_0010_10, 60'h0_0000_0001_ffff_08, 60'h0_8000_0001_7fff_05,
		60'h2_0080_0001_007f_05, 60'h0_0000_00ff_0000_07, 60'h0_0f0f_00f0_0fff_05,
		60'h1_ffff_7fff_8000_0d, 60'h0_0001_0001_0003_00, 60'h0_0005_0002_0002_11};
	logic [43:0] st [8] = '{44'h04_0_8000_0800, 44'h04_1_8000_f800, 44'hfc_0_0001_0010,
		44'h00_0_1234_1234, 44'h10_0_8000_0000, 44'h10_1_8000_ffff, 44'hf0_0_ffff_0000,
		44'hff_2_0001_0002};
	logic [75:0] mt [7] = '{76'h0_00_ffff_0002_ffff_fffe, 76'h1_00_ffff_0002_0001_fffe,
		76'h2_00_0002_ffff_ffff_fffe, 76'h3_00_0002_ffff_0001_fffe,
		76'h4_1f_fffe_0000_ffff_ffc2, 76'h5_1f_fffe_0000_001e_ffc2,
		76'h6_00_12ff_34ff_0000_fe01};
	logic [83:0] dt [4] = '{84'h0_ffff_fff9_0002_fffd_ffff, 84'h1_0001_0000_0002_8000_0000,
		84'h2_1234_fff9_0002_fffd_ffff, 84'h3_ffff_0007_0003_0002_0001};

	always #2 clk = ~clk;

	cpu_alu_mul_div_shift uut (.clk, .nrst, .regAddr, .regWdata, .regWrite, .regRead,
		.regRdata, .reqValid, .req, .wregA, .wregB, .memData, .dividendHigh, .dividendLow,
		.divisor, .divHold, .priorityMsbSet, .repeatActive, .result, .resultHigh,
		.resultValid, .resultToMem, .resultByte, .resultWide, .quotient, .remainder,
		.divWrite, .divBusy, .statusWord, .priorityLevel, .userIrqDisable,
		.programWindowEnable);
	operand_bank bank (.clk, .selA, .selB, .selDiv, .selPair, .divWrite, .quotient,
		.remainder, .wregA, .wregB, .memData, .divisor, .dividendHigh, .dividendLow);

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic results;
		if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		#1 check(regRdata, d);
	endtask

	// operand A: mem copy is x, register copy its inverse on memory-source requests, so a wrong source shows
	task automatic go(input request_type q, input logic [15:0] a, input logic [15:0] b);
		bank.mem = a;
		bank.w[0] = q.srcMem ? ~a : a;
		bank.w[1] = b;
		@(posedge clk);
		reqValid <= 1'b1;
		req <= q;
		@(posedge clk);
		reqValid <= 1'b0;
		#1;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(4'h0, 16'h0000);
		wr(4'h0, 16'hffff);
		rd(4'h0, 16'h0004);
		check(programWindowEnable, 1'b1);
		rd(4'h9, 16'h0000);
		wr(4'h1, 16'h00a0);
		@(posedge clk);
		priorityMsbSet <= 1'b1;
		@(posedge clk);
		priorityMsbSet <= 1'b0;
		#1 check({userIrqDisable, priorityLevel}, 5'h1d);
		rd(4'h0, 16'h000c);
		wr(4'h0, 16'h0000);
		rd(4'h0, 16'h0000);
		check({userIrqDisable, priorityLevel}, 5'h05);
		repeatActive <= 1'b1;
		@(posedge clk);
		#1 check(statusWord[4], 1'b1);
		for (int i = 0; i < 11; i++) begin
			{k, x, y, e, f[7:0]} = at[i];
			r = '0;
			r.op = ao[i];
			r.byteMode = k[1];
			r.srcMem = k[0];
			r.destMem = k[0];
			go(r, x, y);
			check(result, e);
			check({statusWord[8], statusWord[3:0]}, f[7:0]);
			check({resultValid, resultByte, resultToMem}, {1'b1, k[1:0]});
		end
		for (int i = 0; i < 8; i++) begin
			{g, k, x, e} = st[i];
			r = '0;
			r.op = OP_SHIFT;
			r.shiftAmount = g[5:0];
			r.shiftArith = k[0];
			r.srcMem = k[1];
			go(r, x, 16'h0000);
			check(result, e);
		end
		for (int i = 0; i < 7; i++) begin
			{k, g, x, y, e, f} = mt[i];
			r = '0;
			r.op = OP_MUL;
			r.mulMode = mulmode_type'(k[2:0]);
			r.literal = g[4:0];
			go(r, x, y);
			check({resultHigh, result}, {e, f});
			check({resultWide, resultByte, resultValid}, 3'h5);
		end
		for (int i = 0; i < 4; i++) begin
			{k, x, y, z, e, f} = dt[i];
			bank.w[4] = y;
			bank.w[5] = x;
			bank.w[7] = z;
			r = '0;
			r.op = OP_DIV;
			r.divMode = divmode_type'(k[1:0]);
			@(posedge clk);
			reqValid <= 1'b1;
			req <= r;
			n = 0;
			do begin
				@(posedge clk);
				reqValid <= 1'b0;
				divHold <= (i == 1 && n > 3 && n < 7);
				n++;
				#1;
			end while (!divWrite && n < 40);
			check(n, (i == 1) ? 22 : 19);
			if (n >= 40) results();
			@(posedge clk);
			#1 check({bank.w[0], bank.w[1]}, {e, f});
		end
		results();
	end
endmodule // cpu_alu_mul_div_shift_bench
